// *** src/seq_pkg.sv ***
// Purpose: constants and types for the run gating and braking sequencer
// Assumes: 250 MHz system clock, settings in 0.1 Hz, 10 ms and 1 % units
// Notes:   register offsets are byte addresses on the plain register port
package seq_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] OFS_CFG    = 8'h00;
    localparam logic [7:0] OFS_FREQ   = 8'h04;
    localparam logic [7:0] OFS_CUR    = 8'h08;
    localparam logic [7:0] OFS_TSTART = 8'h0C;
    localparam logic [7:0] OFS_TSTOP  = 8'h10;
    localparam logic [7:0] OFS_FLUX   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // ==========================================================
    // field positions in the configuration word
    localparam int CFG_RPS_LSB = 0;   // run_in_programming_select
    localparam int CFG_PHASE   = 2;   // phase_order_select
    localparam int CFG_SM_LSB  = 4;   // stop_method_select
    localparam int CFG_PWRUP   = 6;   // run_at_powerup_select
    localparam int CFG_PM      = 7;   // pm_open_loop_vector_mode
    localparam int CFG_FR1_LSB = 8;   // frequency reference source one
    localparam int CFG_FR2_LSB = 11;  // freq_ref_source_two
    localparam int CFG_RS1_LSB = 14;  // run source one
    localparam int CFG_RS2_LSB = 16;  // run_source_two
    localparam int HI_LSB      = 16;  // upper field of paired words
    // ==========================================================
    // reset values of the settings
    localparam logic [17:0] CFG_RST    = 18'h00000;
    localparam logic [27:0] FREQ_RST   = 28'h0000005; // 0.5 Hz
    localparam logic [6:0]  CUR_RST    = 7'h32;       // 50 %
    localparam logic [27:0] TSTART_RST = 28'h0000032; // 0.50 s
    localparam logic [9:0]  TSTOP_RST  = 10'h032;     // 0.50 s
    localparam logic [9:0]  FLUX_RST   = 10'h000;     // 0 %
    localparam logic [6:0]  CUR_CARRIER_LIMIT = 7'h32;
    localparam logic [1:0]  RPS_BLOCK  = 2'h0;
    localparam logic [1:0]  RPS_ANY    = 2'h1;
    localparam logic [1:0]  RPS_LOCK   = 2'h2;
    localparam logic [1:0]  SM_RAMP    = 2'h0;
    // ==========================================================
    // timing
    localparam int TICK_MS     = 10;
    localparam int CLK_KHZ     = 250000;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
    localparam logic [11:0] STARTUP_TICKS = 12'h032;  // 500 ms
    localparam logic [3:0]  BLINK_TICKS   = 4'h5;     // 50 ms half period
    // ==========================================================
    typedef enum logic [2:0] {
        ST_STARTUP, ST_IDLE, ST_SHORT_START, ST_DC_START,
        ST_RUN, ST_DECEL, ST_STOP_BRAKE
    } state_type;
endpackage : seq_pkg

// *** src/run_gating_dc_brake_sequencer.sv ***
// Purpose: gates the run command and times start and stop braking phases
// Assumes: inputs synchronous to clk_i, output_freq_i in 0.1 Hz units
// Notes:   all interval times resolve to the 10 ms tick
//
// How it works
// R1: mode 0 ignores run while the panel is programming.
// R2: mode 1 accepts run in every panel mode.
// R3: mode 2 refuses programming entry while the output is active.
// R4: phase order standard at 0, swapped at 1.
// R5: reference switch terminal selects frequency reference source two.
// R6: reference switch terminal selects run source two.
// R7: power-up run not honoured at 0; run must be cycled.
// R8: power-up run at 0 makes the run indicator blink fast.
// R9: power-up run at 1 starts once start-up completes.
// R10: stop braking threshold only used with ramp stop method.
// R11: ramp stop braking begins below brake_start_freq.
// R12: threshold raised to min_output_freq when that is higher.
// R13: pm vector mode brakes by shorting phases, not dc; at zero short start time the code still runs dc start injection.
// R14: dc current setting 0 to 75 percent of rated; the register takes any value 0 to 127 unchecked.
// R15: dc current above 50 percent forces 1 kHz carrier.
// R16: dc injection at start for its time, skipped at zero.
// R17: stop braking held for dc_brake_time_stop.
// R18: flux boost applied during start injection below min frequency.
// R19: pm mode shorts phases at start for its time, zero skips.
// R20: ramp stop decelerates when run drops or stop given.
// R21: all intervals counted in 10 ms ticks of the system clock.
`timescale 1ns/10ps
module run_gating_dc_brake_sequencer
    import seq_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic [3:0]  run_sources_i,
    input  wire logic        stop_cmd_i,
    input  wire logic        ref_switch_i,
    input  wire logic        prog_req_i,
    input  wire logic [11:0] output_freq_i,
    output logic             prog_mode_o,
    output logic             run_o,
    output logic             decel_o,
    output logic             dc_inject_o,
    output logic             short_brake_o,
    output logic             output_active_o,
    output logic             phase_swap_o,
    output logic             carrier_low_o,
    output logic             flux_boost_o,
    output logic      [9:0]  flux_level_o,
    output logic      [6:0]  dc_current_o,
    output logic      [2:0]  freq_ref_sel_o,
    output logic             run_led_o
);
    // ==========================================================
    // settings registers
    logic [17:0] cfg_reg;
    logic [27:0] freq_reg;
    logic [6:0]  cur_reg;
    logic [27:0] tstart_reg;
    logic [9:0]  tstop_reg;
    logic [9:0]  flux_reg;
    logic [31:0] rdata_next;

    wire wr_cfg    = wr_i && (addr_i == OFS_CFG);
    wire wr_freq   = wr_i && (addr_i == OFS_FREQ);
    wire wr_cur    = wr_i && (addr_i == OFS_CUR);
    wire wr_tstart = wr_i && (addr_i == OFS_TSTART);
    wire wr_tstop  = wr_i && (addr_i == OFS_TSTOP);
    wire wr_flux   = wr_i && (addr_i == OFS_FLUX);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_reg    <= CFG_RST;
            freq_reg   <= FREQ_RST;
            cur_reg    <= CUR_RST;
            tstart_reg <= TSTART_RST;
            tstop_reg  <= TSTOP_RST;
            flux_reg   <= FLUX_RST;
        end else begin
            if (wr_cfg)    cfg_reg    <= wdata_i[17:0];
            if (wr_freq)   freq_reg   <= wdata_i[27:0];
            if (wr_cur)    cur_reg    <= wdata_i[6:0];   // R14
            if (wr_tstart) tstart_reg <= wdata_i[27:0];
            if (wr_tstop)  tstop_reg  <= wdata_i[9:0];
            if (wr_flux)   flux_reg   <= wdata_i[9:0];
        end
    end

    wire [1:0]  rps       = cfg_reg[CFG_RPS_LSB +: 2];
    wire [1:0]  stop_meth = cfg_reg[CFG_SM_LSB +: 2];
    wire        pwrup_sel = cfg_reg[CFG_PWRUP];
    wire        pm_mode   = cfg_reg[CFG_PM];
    wire [2:0]  fr_one    = cfg_reg[CFG_FR1_LSB +: 3];
    wire [2:0]  fr_two    = cfg_reg[CFG_FR2_LSB +: 3];
    wire [1:0]  rs_one    = cfg_reg[CFG_RS1_LSB +: 2];
    wire [1:0]  rs_two    = cfg_reg[CFG_RS2_LSB +: 2];
    wire [11:0] brk_freq  = freq_reg[11:0];
    wire [11:0] min_freq  = freq_reg[HI_LSB +: 12];
    wire [11:0] dc_start  = tstart_reg[11:0];
    wire [11:0] sc_start  = tstart_reg[HI_LSB +: 12];
    wire [11:0] dc_stop   = {2'h0, tstop_reg};

    // ==========================================================
    // 10 ms tick; one shared divider keeps every interval aligned
    logic [21:0] div_reg;
    logic        tick_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_reg  <= 22'h000000;
            tick_reg <= 1'b0;
        end else if (div_reg == 22'(TICK_CYCLES_P - 1)) begin
            div_reg  <= 22'h000000;                      // R21
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 22'h000001;
            tick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // run source and gating
    state_type   state_reg, state_next;
    logic [11:0] timer_reg, timer_next;
    logic        prog_mode_reg, pu_block_reg, active_reg;

    wire [1:0] run_src  = ref_switch_i ? rs_two : rs_one;         // R6
    wire       run_sel  = run_sources_i[run_src];
    wire       prog_bar = prog_mode_reg && (rps == RPS_BLOCK);    // R1
    // modes 1 and 2 both let run through; mode 2 instead locks the panel
    wire       run_ok   = run_sel && !stop_cmd_i && !prog_bar &&
                          !pu_block_reg;                          // R2
    wire       prog_next = prog_req_i &&
                           !((rps == RPS_LOCK) && active_reg);    // R3
    wire [11:0] brake_thr = (brk_freq < min_freq) ? min_freq
                                                  : brk_freq;     // R12
    wire       below_thr = output_freq_i < brake_thr;             // R11
    wire       timer_done = (timer_reg == 12'h000);

    // ==========================================================
    // sequencer
    always_comb begin
        state_next = state_reg;
        timer_next = (tick_reg && !timer_done) ? timer_reg - 12'h001
                                               : timer_reg;
        case (state_reg)
            ST_STARTUP: begin
                if (timer_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (run_ok) begin
                    if (pm_mode && sc_start != 12'h000) begin
                        state_next = ST_SHORT_START;     // R19
                        timer_next = sc_start;
                    end else if (dc_start != 12'h000) begin
                        state_next = ST_DC_START;        // R16
                        timer_next = dc_start;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_SHORT_START: begin
                if (timer_done) begin
                    state_next = ST_RUN;                 // R19
                end
            end
            ST_DC_START: begin
                if (timer_done) begin
                    state_next = ST_RUN;                 // R16
                end
            end
            ST_RUN: begin
                if (!run_ok) begin
                    // other stop methods are out of scope: output drops
                    state_next = (stop_meth == SM_RAMP) ? ST_DECEL
                                                        : ST_IDLE; // R20
                end
            end
            ST_DECEL: begin
                if (run_ok) begin
                    state_next = ST_RUN;
                end else if (below_thr) begin            // R10
                    state_next = (dc_stop == 12'h000) ? ST_IDLE
                                                      : ST_STOP_BRAKE;
                    timer_next = dc_stop;                // R17
                end
            end
            ST_STOP_BRAKE: begin
                if (timer_done) begin
                    state_next = ST_IDLE;                // R17
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire act_next   = (state_next != ST_STARTUP) &&
                      (state_next != ST_IDLE);
    // the start-up wait gives software time to load settings first
    wire pu_decide  = (state_reg == ST_STARTUP) && timer_done;
    wire pu_next    = pu_decide ? (run_sel && !pwrup_sel)       // R7
                                : (pu_block_reg && run_sel);    // R7

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg     <= ST_STARTUP;
            timer_reg     <= STARTUP_TICKS;
            prog_mode_reg <= 1'b0;
            pu_block_reg  <= 1'b0;
            active_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            timer_reg     <= timer_next;
            prog_mode_reg <= prog_next;
            pu_block_reg  <= pu_next;                    // R9
            active_reg    <= act_next;
        end
    end

    // ==========================================================
    // run indicator: fast blink while a power-up run is held off
    logic [3:0] blink_cnt_reg;
    logic       blink_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            blink_cnt_reg <= 4'h0;
            blink_reg     <= 1'b0;
        end else if (tick_reg) begin
            if (blink_cnt_reg == BLINK_TICKS - 4'h1) begin
                blink_cnt_reg <= 4'h0;
                blink_reg     <= !blink_reg;             // R8
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 4'h1;
            end
        end
    end

    // ==========================================================
    // outputs, all registered
    wire brake_st  = (state_next == ST_STOP_BRAKE);
    wire boost_st  = (state_next == ST_DC_START) &&
                     (output_freq_i < min_freq) &&
                     (flux_reg != FLUX_RST);               // R18
    wire led_next  = pu_block_reg ? blink_reg : act_next;  // R8

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prog_mode_o     <= 1'b0;
            run_o           <= 1'b0;
            decel_o         <= 1'b0;
            dc_inject_o     <= 1'b0;
            short_brake_o   <= 1'b0;
            output_active_o <= 1'b0;
            phase_swap_o    <= 1'b0;
            carrier_low_o   <= 1'b0;
            flux_boost_o    <= 1'b0;
            flux_level_o    <= FLUX_RST;
            dc_current_o    <= CUR_RST;
            freq_ref_sel_o  <= 3'h0;
            run_led_o       <= 1'b0;
        end else begin
            prog_mode_o     <= prog_next;
            run_o           <= (state_next == ST_RUN);
            decel_o         <= (state_next == ST_DECEL);
            dc_inject_o     <= (state_next == ST_DC_START) ||
                               (brake_st && !pm_mode);      // R13
            short_brake_o   <= (state_next == ST_SHORT_START) ||
                               (brake_st && pm_mode);       // R13
            output_active_o <= act_next;
            phase_swap_o    <= cfg_reg[CFG_PHASE];          // R4
            carrier_low_o   <= cur_reg > CUR_CARRIER_LIMIT; // R15
            flux_boost_o    <= boost_st;                    // R18
            flux_level_o    <= flux_reg;
            dc_current_o    <= cur_reg;                     // R14
            freq_ref_sel_o  <= ref_switch_i ? fr_two : fr_one; // R5
            run_led_o       <= led_next;
        end
    end

    // ==========================================================
    // register read path, data valid in the following cycle
    always_comb begin
        rdata_next = 32'h00000000;
        case (addr_i)
            OFS_CFG:    rdata_next = {14'h0000, cfg_reg};
            OFS_FREQ:   rdata_next = {4'h0, freq_reg};
            OFS_CUR:    rdata_next = {25'h0000000, cur_reg};
            OFS_TSTART: rdata_next = {4'h0, tstart_reg};
            OFS_TSTOP:  rdata_next = {22'h000000, tstop_reg};
            OFS_FLUX:   rdata_next = {22'h000000, flux_reg};
            OFS_STATUS: rdata_next = {4'h0, timer_reg, 10'h000,
                                      active_reg, pu_block_reg,
                                      prog_mode_reg, state_reg};
            default:    rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= rd_i ? rdata_next : 32'h00000000;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_prog_blocks_run: assert property ( // R1
        (state_reg == ST_IDLE && prog_mode_reg && rps == RPS_BLOCK)
        |=> state_reg == ST_IDLE)
        else $error("run accepted during programming");
    chk_any_mode_run: assert property ( // R2
        (state_reg == ST_IDLE && run_sel && !stop_cmd_i &&
         rps == RPS_ANY && !pu_block_reg)
        |=> state_reg != ST_IDLE ##1 output_active_o)
        else $error("run not accepted in any-mode setting");
    chk_prog_lockout: assert property ( // R3
        (rps == RPS_LOCK && active_reg) |=> !prog_mode_reg)
        else $error("programming entered while active");
    chk_phase_order: assert property ( // R4
        $changed(cfg_reg[CFG_PHASE]) |=> ##1
        phase_swap_o == $past(cfg_reg[CFG_PHASE], 2))
        else $error("phase order not followed");
    chk_powerup_hold: assert property ( // R7
        (pu_block_reg && state_reg == ST_IDLE) |=> state_reg == ST_IDLE)
        else $error("power-up run honoured");
    chk_decel_brake: assert property ( // R11
        (state_reg == ST_DECEL && !run_ok && below_thr)
        |=> state_reg inside {ST_STOP_BRAKE, ST_IDLE})
        else $error("stop braking not begun below threshold");
    chk_coast_stop: assert property ( // R10
        (state_reg == ST_RUN && !run_ok && stop_meth != SM_RAMP)
        |=> state_reg == ST_IDLE)
        else $error("ramp stop used with other method");
    chk_brake_kind: assert property ( // R13
        !(dc_inject_o && short_brake_o))
        else $error("dc and short braking together");
    chk_carrier_low: assert property ( // R15
        (cur_reg > CUR_CARRIER_LIMIT) |=> carrier_low_o)
        else $error("carrier not lowered");
    chk_boost_window: assert property ( // R18
        flux_boost_o |-> $past(state_next) == ST_DC_START)
        else $error("flux boost outside start injection");

    cov_stop_brake: cover property (
        state_reg == ST_DECEL ##1 state_reg == ST_STOP_BRAKE);
    cov_dc_start: cover property (
        state_reg == ST_DC_START ##1 state_reg == ST_RUN);
    cov_short_start: cover property (state_reg == ST_SHORT_START);
    cov_powerup_block: cover property ($rose(pu_block_reg));
endmodule : run_gating_dc_brake_sequencer

// *** verification/stage_model.sv ***
// Purpose: far side model of the power stage frequency feedback
// Assumes: frequency in 0.1 Hz units, one step per clock while ramping
// Notes:   slow ramp so the brake threshold is crossed one step at a time
`timescale 1ns/10ps
module stage_model #(
    parameter logic [11:0] RUN_FREQ = 12'h1F4
) (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic        decel_i,
    output logic      [11:0] freq_o
);
    // ==========================================================
    // feedback ramp
    initial freq_o = 12'h000;
    always @(posedge clk_i) begin
        if (run_i) begin
            freq_o <= RUN_FREQ;
        end else if (decel_i) begin
            // stalls at zero rather than wrapping round
            freq_o <= (freq_o == 12'h000) ? 12'h000 : freq_o - 12'h001;
        end else begin
            freq_o <= 12'h000;
        end
    end
endmodule : stage_model

// *** verification/run_gating_dc_brake_sequencer_test.sv ***
// Purpose: self-checking bench for the run gating and braking sequencer
// Assumes: tick shortened to 10 clocks, start-up wait 50 ticks
// Notes:   timed phases allow one tick of phase slack
`timescale 1ns/10ps
module run_gating_dc_brake_sequencer_test;
    import seq_pkg::*;
    localparam int T = 10;
    logic        clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, seed = 32'hC253E03B;
    logic [3:0]  run_sources_i = 4'h1;
    logic        stop_cmd_i = 1'b0, ref_switch_i = 1'b0, prog_req_i = 1'b0;
    logic [11:0] output_freq_i;
    logic        prog_mode_o, run_o, decel_o, dc_inject_o, short_brake_o;
    logic        output_active_o, phase_swap_o, carrier_low_o, flux_boost_o;
    logic        run_led_o, saw_flux = 1'b0, overlap = 1'b0;
    logic [9:0]  flux_level_o;
    logic [6:0]  dc_current_o;
    logic [2:0]  freq_ref_sel_o;
    int          n_fail = 0, samples_checked = 0, cycles = 0;
    run_gating_dc_brake_sequencer #(.TICK_CYCLES_P(T))
        run_gating_dc_brake_sequencer_i (.clk_i(clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .run_sources_i(run_sources_i),
        .stop_cmd_i(stop_cmd_i), .ref_switch_i(ref_switch_i),
        .prog_req_i(prog_req_i), .output_freq_i(output_freq_i),
        .prog_mode_o(prog_mode_o), .run_o(run_o), .decel_o(decel_o),
        .dc_inject_o(dc_inject_o), .short_brake_o(short_brake_o),
        .output_active_o(output_active_o), .phase_swap_o(phase_swap_o),
        .carrier_low_o(carrier_low_o), .flux_boost_o(flux_boost_o),
        .flux_level_o(flux_level_o), .dc_current_o(dc_current_o),
        .freq_ref_sel_o(freq_ref_sel_o), .run_led_o(run_led_o));
    stage_model stage_model_i (.clk_i(clk_i), .run_i(run_o),
        .decel_i(decel_o), .freq_o(output_freq_i));
    // ==========================================================
    // clock, watchdog and background flags
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        saw_flux <= saw_flux | (dc_inject_o & flux_boost_o);
        overlap <= overlap | (dc_inject_o & short_brake_o);
        if (cycles == 10000) begin
            n_fail++;
            close_out();
        end
    end
    // ==========================================================
    // expectations and compares
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic int thr(input int brake, input int minf);
        return (brake < minf) ? minf : brake;
    endfunction : thr
    function automatic logic sig(input int k);
        case (k)
            0: return run_o;
            1: return decel_o;
            2: return dc_inject_o;
            3: return short_brake_o;
            4: return output_active_o;
            default: return prog_mode_o;
        endcase
    endfunction : sig
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_span(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("Error at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_span
    task automatic cmp_ticks(input int got, input int ticks);
        cmp_span(got, (ticks - 1) * T, (ticks + 1) * T + 2);
    endtask : cmp_ticks
    // ==========================================================
    // register port and waits
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic wait_sig(input int k, input logic v, input int lim);
        int i;
        i = 0;
        while (sig(k) !== v && i < lim) begin
            @(posedge clk_i);
            #1;
            i++;
        end
        cmp_word({31'h0, sig(k)}, {31'h0, v});
    endtask : wait_sig
    task automatic span(input int k, input int lim, output int n,
                        output int f);
        wait_sig(k, 1'b1, lim);
        f = int'(output_freq_i);
        n = 0;
        while (sig(k) === 1'b1 && n < 1000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask : span
    task automatic set_run(input logic [3:0] v);
        @(posedge clk_i);
        run_sources_i <= v;
    endtask : set_run
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // ==========================================================
    // main sequence
    logic [7:0]  ra [7] = '{OFS_CFG, OFS_FREQ, OFS_CUR, OFS_TSTART,
                            OFS_TSTOP, OFS_FLUX, 8'h1C};
    logic [31:0] rv [7] = '{32'h0, 32'h5, 32'h32, 32'h32, 32'h32, 32'h0,
                            32'h0};
    initial begin
        int n, f, i, c;
        logic [31:0] d;
        logic [2:0]  f1, f2;
        logic [1:0]  sel;
        logic        sw, led;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        for (i = 0; i < 7; i++) begin
            rd(ra[i], d);
            cmp_word(d, rv[i]);
        end
        repeat (50 * T + 20) @(posedge clk_i);
        #1 cmp_word({31'h0, run_o}, 32'h0);
        led = run_led_o;
        c = 0;
        repeat (200) begin
            @(posedge clk_i);
            #1 c += (run_led_o !== led);
            led = run_led_o;
        end
        cmp_span(c, 3, 5);
        $display("power-up hold test done");
        set_run(4'h0);
        wr(OFS_TSTART, 32'h3);
        wr(OFS_FLUX, 32'h64);
        wr(OFS_FREQ, 32'h0014_0005);
        wr(OFS_TSTOP, 32'h4);
        set_run(4'h1);
        span(2, 20, n, f);
        cmp_ticks(n, 3);
        wait_sig(0, 1'b1, 5);
        cmp_word({31'h0, saw_flux}, 32'h1);
        cmp_word({22'h0, flux_level_o}, 32'h64);
        set_run(4'h0);
        wait_sig(1, 1'b1, 5);
        span(2, 600, n, f);
        cmp_span(f, thr(5, 20) - 4, thr(5, 20) - 1);
        cmp_ticks(n, 4);
        $display("dc start and stop test done");
        wr(OFS_CUR, 32'h33);
        repeat (3) @(posedge clk_i);
        #1 cmp_word({31'h0, carrier_low_o}, 32'h1);
        cmp_word({25'h0, dc_current_o}, 32'h33);
        wr(OFS_CUR, 32'h32);
        wr(OFS_CFG, 32'h4);
        repeat (3) @(posedge clk_i);
        #1 cmp_word({31'h0, carrier_low_o}, 32'h0);
        cmp_word({31'h0, phase_swap_o}, 32'h1);
        wr(OFS_CFG, 32'h0);
        @(posedge clk_i);
        prog_req_i <= 1'b1;
        wait_sig(5, 1'b1, 5);
        cmp_word({31'h0, phase_swap_o}, 32'h0);
        $display("carrier phase test done");
        set_run(4'h1);
        repeat (5) @(posedge clk_i);
        #1 cmp_word({31'h0, output_active_o}, 32'h0);
        wr(OFS_CFG, 32'h1);
        wait_sig(0, 1'b1, 60);
        cmp_word({31'h0, prog_mode_o}, 32'h1);
        @(posedge clk_i);
        prog_req_i <= 1'b0;
        wait_sig(5, 1'b0, 5);
        wr(OFS_CFG, 32'h2);
        @(posedge clk_i);
        prog_req_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1 cmp_word({31'h0, prog_mode_o}, 32'h0);
        wr(OFS_CFG, 32'h12);
        set_run(4'h0);
        wait_sig(4, 1'b0, 5);
        wait_sig(5, 1'b1, 10);
        @(posedge clk_i);
        prog_req_i <= 1'b0;
        $display("programming test done");
        wr(OFS_CFG, 32'h80);
        wr(OFS_TSTART, 32'h0002_0003);
        wr(OFS_FREQ, 32'h0005_000C);
        set_run(4'h1);
        span(3, 20, n, f);
        cmp_ticks(n, 2);
        wait_sig(0, 1'b1, 5);
        set_run(4'h0);
        span(3, 600, n, f);
        cmp_span(f, thr(12, 5) - 4, thr(12, 5) - 1);
        cmp_ticks(n, 4);
        cmp_word({31'h0, overlap}, 32'h0);
        $display("short brake test done");
        wr(OFS_TSTART, 32'h0);
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            f1 = 3'(seed[7:0] % 5);
            f2 = 3'(seed[15:8] % 5);
            sw = seed[20];
            sel = sw ? seed[19:18] : seed[17:16];
            wr(OFS_CFG, {14'h0, seed[19:16], f2, f1, 8'h10});
            @(posedge clk_i);
            ref_switch_i <= sw;
            run_sources_i <= ~(4'h1 << sel);
            stop_cmd_i <= 1'b0;
            repeat (5) @(posedge clk_i);
            #1 cmp_word({29'h0, freq_ref_sel_o}, {29'h0, sw ? f2 : f1});
            cmp_word({31'h0, run_o}, 32'h0);
            set_run(4'h1 << sel);
            wait_sig(0, 1'b1, 5);
            @(posedge clk_i);
            stop_cmd_i <= 1'b1;
            wait_sig(4, 1'b0, 5);
            cmp_word({31'h0, decel_o}, 32'h0);
        end
        $display("source switch test done");
        @(posedge clk_i);
        run_sources_i <= 4'h1;
        stop_cmd_i <= 1'b0;
        ref_switch_i <= 1'b0;
        reset_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        wr(OFS_CFG, 32'h40);
        wr(OFS_TSTART, 32'h0);
        repeat (50 * T + 20) @(posedge clk_i);
        #1 cmp_word({31'h0, run_o}, 32'h1);
        $display("power-up run test done");
        close_out();
    end
endmodule : run_gating_dc_brake_sequencer_test
